// File: rtl/gport_card.sv
`include "gport_cfg.svh"
// Card end: drives detect pins and issues config accesses
module gport_card
	import gport_pkg::*;
#(
	parameter logic CARD_NEW       = 1'b1,
	parameter logic CARD_UNIVERSAL = 1'b1
)(
	input  wire logic          ref_clk_i,
	input  wire logic          rst_i,
	gport_if.card              port,
	input  wire logic [7:0]    addr_i,
	input  wire logic [31:0]   wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output logic [31:0]        rdata_o,
	output gport_pkg::sig_mode_t mode_o
);
	import gport_pkg::*;
	logic [2:0] b_sync_reg;
	logic [1:0] settle_reg;
	sig_mode_t  mode_reg, mode_next;
	logic       done_reg;
	logic       agree_w;
	// Stage reset values are not the pin: wait until all stages are filled
	assign agree_w = (settle_reg == 2'h3) && (b_sync_reg[1] == b_sync_reg[2]);
	// Resolve mode once from board pin
	always_comb
	begin
		mode_next = mode_reg;
		if (!done_reg && agree_w)
			mode_next = (!b_sync_reg[2] && CARD_NEW) ? MODE_NEW :
				(CARD_UNIVERSAL ? MODE_LEGACY : MODE_ILLEGAL);
	end
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			b_sync_reg <= 3'h7;
			settle_reg <= 2'h0;
			mode_reg   <= MODE_LEGACY;
			done_reg   <= 1'b0;
		end
		else
		begin
			b_sync_reg <= {b_sync_reg[1:0], port.board_detect_pin};
			settle_reg <= (settle_reg == 2'h3) ? settle_reg : settle_reg + 2'h1;
			mode_reg   <= mode_next;
			done_reg   <= done_reg || agree_w;
		end
	end
	assign port.card_detect_pin       = !CARD_NEW;
	assign port.card_voltage_type_pin = !CARD_UNIVERSAL;
	assign port.cfg_addr  = addr_i;
	assign port.cfg_wdata = wdata_i;
	assign port.cfg_wr    = wr_i;
	assign port.cfg_rd    = rd_i;
	assign rdata_o = port.cfg_rdata;
	assign mode_o  = mode_reg;
endmodule

// File: rtl/gport_cfg.svh
`ifndef GPORT_CFG_SVH
`define GPORT_CFG_SVH
`define CAP_PTR_OFS      8'h34
`define CAP_BASE         8'h40
`define STAT_OFS         8'h44
`define CMD_OFS          8'h48
`define CTRL_OFS         8'h4C
`define MODE_BIT         3
`define RATE_4X          3'h1
`define RATE_8X          3'h2
`define RATE_BOTH        3'h3
`define LEGACY_RATE      3'h7
`define CAP_ID_VAL       8'h5A
`define MAJOR_REV        4'h3
`endif

// File: rtl/gport_core.sv
`include "gport_cfg.svh"
// Core-logic end: resolves mode, holds status/command, answers config reads
module gport_core
	import gport_pkg::*;
#(
	parameter logic       BOARD_NEW      = 1'b1,
	parameter logic       BOARD_LEGACY   = 1'b1,
	parameter logic [2:0] NEW_RATES      = 3'h3,
	parameter logic       INSIDE_COHERENT = 1'b0
)(
	input  wire logic          ref_clk_i,
	input  wire logic          rst_i,
	gport_if.dev               port,
	input  wire logic [1:0]    aperture_hit_i,
	output logic               snoop_o,
	output logic               fwd_write_o,
	output gport_pkg::sig_mode_t mode_o,
	output gport_pkg::speed_t  speed_o,
	output logic               enable_o
);
	import gport_pkg::*;
	// Pins sampled and edges needed before the stages hold real pin values
	localparam int         PIN_CNT    = 2;
	localparam logic [1:0] SETTLE_END = 2'h3;
	// Synchroniser stages, card detect in bit 1, voltage type in bit 0
	logic [PIN_CNT-1:0]    sync1_reg, sync1_next;
	logic [PIN_CNT-1:0]    sync2_reg, sync2_next;
	logic [PIN_CNT-1:0]    sync3_reg, sync3_next;
	// Resolve window state
	logic [1:0]            settle_reg, settle_next;
	logic                  open_reg, open_next;
	sig_mode_t             mode_reg, mode_next;
	// Software visible state
	logic [31:0]           cmd_reg, cmd_next;
	logic [31:0]           rdata_reg, rdata_next;
	speed_t                speed_reg, speed_next;
	// Coherency and forwarding decisions
	logic                  snoop_reg, snoop_next;
	logic                  fwd_reg, fwd_next;
	// Combinational words and strobes
	logic [31:0]           stat_w;
	logic [31:0]           cap_w;
	logic                  agree_w;
	logic                  cmd_wr_w;

	// Resolve signaling mode from grounded pins
	function automatic sig_mode_t resolve(input logic card_gnd, input logic type_gnd);
		if (card_gnd && BOARD_NEW && type_gnd)
			return MODE_NEW;
		else if (card_gnd && !(BOARD_LEGACY && type_gnd))
			return MODE_ILLEGAL; // Grounded card that cannot fall back
		else if (!BOARD_LEGACY)
			return MODE_ILLEGAL; // New-only board cannot run a legacy card
		else
			return MODE_LEGACY;
	endfunction

	// Match of a bus address against one register offset
	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction

	// Speed chosen by a command code while the mode flag is set
	function automatic speed_t rate_sel(input sig_mode_t mode, input logic [2:0] code);
		if (mode != MODE_NEW)
			return SPD_NONE;
		else if (code == `RATE_4X)
			return SPD_4X;
		else if (code == `RATE_8X)
			return SPD_8X;
		else
			return SPD_NONE; // Reserved codes select nothing
	endfunction

	// Three-flop synchroniser for the card pins
	always_comb
	begin
		sync1_next = {port.card_detect_pin, port.card_voltage_type_pin};
		sync2_next = sync1_reg;
		sync3_next = sync2_reg;
	end
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
			sync3_reg <= 2'h0;
		end
		else
		begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			sync3_reg <= sync3_next;
		end
	end

	// Stage reset values are not pins: wait until all three stages are filled
	assign agree_w = (settle_reg == SETTLE_END) && (sync2_reg == sync3_reg);
	always_comb
	begin
		settle_next = settle_reg;
		open_next   = open_reg;
		if (settle_reg != SETTLE_END)
			settle_next = settle_reg + 2'h1;
		if (open_reg && agree_w)
			open_next = 1'b0; // Window stays shut until the next reset
	end
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			settle_reg <= 2'h0;
			open_reg   <= 1'b1;
		end
		else
		begin
			settle_reg <= settle_next;
			open_reg   <= open_next;
		end
	end

	// Mode taken once as the window closes, then held
	always_comb
	begin
		mode_next = mode_reg;
		if (open_reg && agree_w)
			mode_next = resolve(!sync3_reg[1], !sync3_reg[0]);
	end
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			mode_reg <= MODE_LEGACY;
		else
			mode_reg <= mode_next;
	end

	// Status word: flag and mode dependent rate field
	assign stat_w = {28'h0, (mode_reg == MODE_NEW), (mode_reg == MODE_NEW) ? NEW_RATES : `LEGACY_RATE};
	// Identifier word: major revision, null next pointer, capability code
	assign cap_w = {8'h00, `MAJOR_REV, 4'h0, 8'h00, `CAP_ID_VAL}; // ID value arbitrary
	// Command write strobe
	assign cmd_wr_w = port.cfg_wr && addr_is(port.cfg_addr, `CMD_OFS);

	// Command register keeps the enables and the rate field
	always_comb
	begin
		cmd_next = cmd_reg;
		if (cmd_wr_w)
			cmd_next = {22'h0, port.cfg_wdata[9:8], 5'h0, port.cfg_wdata[2:0]};
	end
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			cmd_reg <= 32'h0;
		else
			cmd_reg <= cmd_next;
	end

	// Read data stand in the cycle after the read strobe only
	always_comb
	begin
		rdata_next = 32'h0;
		if (port.cfg_rd)
		begin
			unique case (port.cfg_addr)
				`CAP_PTR_OFS: rdata_next = {24'h0, `CAP_BASE};
				`CAP_BASE:    rdata_next = cap_w;
				`STAT_OFS:    rdata_next = stat_w;
				`CMD_OFS:     rdata_next = cmd_reg;
				default:      rdata_next = 32'h0; // Unmapped offsets read zero
			endcase
		end
	end
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_reg <= 32'h0;
		else
			rdata_reg <= rdata_next;
	end

	// Speed decode; new mode means single-edge strobes, no long reads
	always_comb
	begin
		speed_next = rate_sel(mode_reg, cmd_reg[2:0]);
	end
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			speed_reg <= SPD_NONE;
		else
			speed_reg <= speed_next;
	end

	// Snoop outside aperture always, inside optional forward writes
	always_comb
	begin
		snoop_next = !aperture_hit_i[0] || INSIDE_COHERENT;
		fwd_next   = aperture_hit_i[1];
	end
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			snoop_reg <= 1'b1;
			fwd_reg   <= 1'b0;
		end
		else
		begin
			snoop_reg <= snoop_next;
			fwd_reg   <= fwd_next;
		end
	end

	// Outputs; whole register set lives in this one bridge function
	assign port.board_detect_pin = !BOARD_NEW;
	assign port.cfg_rdata = rdata_reg;
	assign mode_o      = mode_reg;
	assign speed_o     = speed_reg;
	assign enable_o    = cmd_reg[8];
	assign snoop_o     = snoop_reg;
	assign fwd_write_o = fwd_reg;
endmodule

// File: rtl/gport_if.sv
interface gport_if;
	logic board_detect_pin;
	logic card_detect_pin;
	logic card_voltage_type_pin;
	logic [7:0]  cfg_addr;
	logic [31:0] cfg_wdata;
	logic        cfg_wr;
	logic        cfg_rd;
	logic [31:0] cfg_rdata;
	modport dev (input card_detect_pin, card_voltage_type_pin, cfg_addr, cfg_wdata, cfg_wr, cfg_rd,
		output board_detect_pin, cfg_rdata);
	modport card (output card_detect_pin, card_voltage_type_pin, cfg_addr, cfg_wdata, cfg_wr, cfg_rd,
		input board_detect_pin, cfg_rdata);
endinterface

// File: rtl/gport_pkg.sv
package gport_pkg;
	typedef enum logic [1:0] {MODE_LEGACY, MODE_NEW, MODE_ILLEGAL} sig_mode_t;
	typedef enum logic [1:0] {SPD_NONE, SPD_4X, SPD_8X} speed_t;
endpackage

// File: verif/gport_checker.sv
`include "gport_cfg.svh"
// Watches the wire between the two ends
module gport_checker (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        board_detect_pin,
	input  wire logic        card_detect_pin,
	input  wire logic        card_voltage_type_pin,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [31:0] cfg_wdata,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [31:0] cfg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] up_reg;
	logic       st_rd;
	// Cycles since release, so the mode has settled
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			up_reg <= 3'h0;
		else if (up_reg != 3'h7)
			up_reg <= up_reg + 3'h1;
	end
	assign st_rd = cfg_rd && cfg_addr == `STAT_OFS;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	property p_new_flag;
		up_reg == 3'h7 && st_rd && !board_detect_pin && !card_detect_pin && !card_voltage_type_pin |=> cfg_rdata[3];
	endproperty
	a_new_flag: assert property (p_new_flag) else $error("mode flag low");
	property p_rate;
		$past(st_rd) && cfg_rdata[3] |-> cfg_rdata[2:0] inside {`RATE_4X, `RATE_8X, `RATE_BOTH};
	endproperty
	a_rate: assert property (p_rate) else $error("bad rate code");
	property p_board_fixed;
		up_reg == 3'h7 |-> $stable(board_detect_pin);
	endproperty
	a_board_fixed: assert property (p_board_fixed) else $error("board pin moved");
	property p_card_fixed;
		up_reg == 3'h7 |-> $stable({card_detect_pin, card_voltage_type_pin});
	endproperty
	a_card_fixed: assert property (p_card_fixed) else $error("card pins moved");
	property p_cmd_rate;
		cfg_wr && cfg_addr == `CMD_OFS ##1 cfg_rd && cfg_addr == `CMD_OFS |=> cfg_rdata == ($past(cfg_wdata, 2) & 32'h303);
	endproperty
	a_cmd_rate: assert property (p_cmd_rate) else $error("command readback");
	property p_cap_ptr;
		cfg_rd && cfg_addr == `CAP_PTR_OFS |=> cfg_rdata[7:0] == `CAP_BASE;
	endproperty
	a_cap_ptr: assert property (p_cap_ptr) else $error("cap pointer");
	property p_cap_rev;
		cfg_rd && cfg_addr == `CAP_BASE |=> cfg_rdata[31:20] == {8'h00, `MAJOR_REV};
	endproperty
	a_cap_rev: assert property (p_cap_rev) else $error("cap revision");
	property p_stat_hold;
		st_rd ##1 st_rd |=> $stable(cfg_rdata);
	endproperty
	a_stat_hold: assert property (p_stat_hold) else $error("status changed");
endmodule

// File: verif/tb_top.sv
`include "gport_cfg.svh"
module tb_top;
	import gport_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk_i, rst_i, wr, rd, snoop, fwd, en;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic [1:0]  ap;
	sig_mode_t   core_mode, card_mode;
	speed_t      speed;
	int          num_errors, checks_done;
	gport_if i_gport_if();
	gport_core i_gport_core(.ref_clk_i(ref_clk_i), .rst_i(rst_i), .port(i_gport_if), .aperture_hit_i(ap),
		.snoop_o(snoop), .fwd_write_o(fwd), .mode_o(core_mode), .speed_o(speed), .enable_o(en));
	gport_card i_gport_card(.ref_clk_i(ref_clk_i), .rst_i(rst_i), .port(i_gport_if), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .mode_o(card_mode));
	gport_checker i_gport_checker(.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.board_detect_pin(i_gport_if.board_detect_pin), .card_detect_pin(i_gport_if.card_detect_pin),
		.card_voltage_type_pin(i_gport_if.card_voltage_type_pin), .cfg_addr(i_gport_if.cfg_addr),
		.cfg_wdata(i_gport_if.cfg_wdata), .cfg_wr(i_gport_if.cfg_wr), .cfg_rd(i_gport_if.cfg_rd),
		.cfg_rdata(i_gport_if.cfg_rdata));
	// Clock and watchdog
	initial
	begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	initial
	begin
		repeat (2000) @(posedge ref_clk_i);
		num_errors++;
		summarize();
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// First access write or read, then a read back to back
	task automatic pair(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge ref_clk_i);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		#1;
	endtask
	task automatic t_regs;
		chk(32'(core_mode), 32'(MODE_NEW));
		chk(32'(card_mode), 32'(MODE_NEW));
		pair(`STAT_OFS, 32'h0, 1'b0);
		chk({28'h0, rdata[3:0]}, {28'h0, 1'b1, `RATE_BOTH});
		pair(`CAP_PTR_OFS, 32'h0, 1'b0);
		chk({24'h0, rdata[7:0]}, {24'h0, `CAP_BASE});
		pair(`CAP_BASE, 32'h0, 1'b0);
		chk({28'h0, rdata[23:20]}, {28'h0, `MAJOR_REV});
		for (int i = 1; i < 3; i++)
		begin
			pair(`CMD_OFS, 32'h100 + i, 1'b1);
			chk(rdata, 32'h100 + i);
			chk({31'h0, en}, 32'h1);
			chk(32'(speed), 32'(i == 1 ? SPD_4X : SPD_8X));
		end
	endtask
	task automatic t_coh;
		ap <= 2'b00;
		repeat (3) @(posedge ref_clk_i);
		chk({30'h0, snoop, fwd}, 32'h2);
		ap <= 2'b01;
		repeat (3) @(posedge ref_clk_i);
		chk({31'h0, snoop}, 32'h0);
		ap <= 2'b10;
		repeat (3) @(posedge ref_clk_i);
		chk({31'h0, fwd}, 32'h1);
	endtask
	task automatic summarize;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		{rst_i, addr, wdata, wr, rd, ap} = {1'b1, 8'h00, 32'h0, 1'b0, 1'b0, 2'b00};
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge ref_clk_i);
		t_regs();
		@(posedge ref_clk_i);
		t_coh();
		summarize();
	end
endmodule
